// ### core/cst_defs.svh
// Purpose: constants of the clock source, trim and sleep entry block
// Assumes: 100 MHz system clock, registers reached over a plain strobe port
// Notes: times are given in ns, cycle counts are derived from them
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

// register port
`define CST_ADDR_W 8
`define CST_DATA_W 8
`define CST_REG_TRIM 8'h00
`define CST_REG_CTRL 8'h01
`define CST_REG_STATUS 8'h02
`define CST_REG_CONFIG 8'h03

// control register fields
`define CST_CTRL_ARM 5
`define CST_CTRL_MODE_LO 3
`define CST_CTRL_MODE_MID 4
`define CST_CTRL_MODE_HI 2
`define CST_CTRL_RESET 8'h00

// status register fields
`define CST_STAT_SLEEP 0
`define CST_STAT_HALT 1
`define CST_STAT_CFGERR 2
`define CST_STAT_MODEERR 3

// clock source select codes
`define CST_SRC_EXT 4'h0
`define CST_SRC_RC1 4'h1
`define CST_SRC_RC2 4'h2
`define CST_SRC_RC4 4'h3
`define CST_SRC_RC8 4'h4

// start-up select codes
`define CST_SUT_NONE 2'h0
`define CST_SUT_SHORT 2'h1
`define CST_SUT_LONG 2'h2
`define CST_SUT_RSVD 2'h3

// factory default configuration, also the fallback for unsupported codes
`define CST_SRC_FACTORY `CST_SRC_RC1
`define CST_SUT_FACTORY `CST_SUT_LONG

// sleep mode codes
`define CST_SM_IDLE 3'h0
`define CST_SM_NOISE 3'h1
`define CST_SM_PDOWN 3'h2
`define CST_SM_PSAVE 3'h3
`define CST_SM_RSVD4 3'h4
`define CST_SM_RSVD5 3'h5
`define CST_SM_STBY 3'h6
`define CST_SM_XSTBY 3'h7

// signature row
`define CST_SIG_AW 2
`define CST_SIG_DW 16
`define CST_SIG_CAL_ADDR 2'h0

// timing
`define CST_CLK_PERIOD_NS 10
`define CST_DLY_SHORT_NS 4100000
`define CST_DLY_LONG_NS 65000000
`define CST_DLY_SHORT_CYC ((`CST_DLY_SHORT_NS + `CST_CLK_PERIOD_NS - 1) / `CST_CLK_PERIOD_NS)
`define CST_DLY_LONG_CYC ((`CST_DLY_LONG_NS + `CST_CLK_PERIOD_NS - 1) / `CST_CLK_PERIOD_NS)
`define CST_STARTUP_CK 23'h000006
`define CST_WAKE_HALT_CK 23'h000004
`define CST_CNT_W 23
`define CST_CNT_ONE 23'h000001

`endif

// ### core/cst_pkg.sv
// Purpose: types of the clock source, trim and sleep entry block
// Assumes: cst_defs.svh gives the widths
// Notes: the whole state of the main module is one struct
`include "cst_defs.svh"

package cst_pkg;

  // one-hot sequencer states
  typedef enum logic [3:0] {
    CST_ST_TIMEOUT = 4'h1,
    CST_ST_RUN = 4'h2,
    CST_ST_SLEEP = 4'h4,
    CST_ST_WAKE = 4'h8
  } cst_state_t;

  // all state of the main module
  typedef struct packed {
    cst_state_t state;
    logic [`CST_CNT_W-1:0] cnt;
    logic [7:0] trim;
    logic sleepArm;
    logic [2:0] sleepMode;
    logic [3:0] srcSel;
    logic [1:0] sutSel;
    logic oscOpt;
    logic legacy;
    logic cfgErr;
    logic modeErr;
    logic resume;
    logic [`CST_DATA_W-1:0] rdData;
  } cst_regs_t;

endpackage

// ### core/cst_sig_rom.sv
// Purpose: signature row holding the factory calibration bytes
// Assumes: contents fixed at build time
// Notes: read data come out of a register, one cycle after the address
`timescale 1ns/1ps
`include "cst_defs.svh"

module cst_sig_rom #(
  // calibration bytes per nominal frequency; values are arbitrary
  parameter logic [7:0] CAL_1MHZ = 8'h80,
  parameter logic [7:0] CAL_2MHZ = 8'h81,
  parameter logic [7:0] CAL_4MHZ = 8'h82,
  parameter logic [7:0] CAL_8MHZ = 8'h83
) (
  input wire logic clk,
  input wire logic [`CST_SIG_AW-1:0] addr,
  output logic [`CST_SIG_DW-1:0] rdData
);

  // row contents: calibration in the high byte, low byte unused
  logic [`CST_SIG_DW-1:0] row [0:3];

  assign row[0] = {CAL_1MHZ, 8'h00};
  assign row[1] = {CAL_2MHZ, 8'h00};
  assign row[2] = {CAL_4MHZ, 8'h00};
  assign row[3] = {CAL_8MHZ, 8'h00};

  // registered read port
  always_ff @(posedge clk) begin
    rdData <= row[addr];
  end

endmodule

// ### core/cst_clock_ctrl.sv
// Purpose: clock source select, oscillator trim and sleep entry/wake sequencing
// Assumes: configuration inputs are static; wdtTick comes from the watchdog oscillator
// Notes: registers at trim, control, status and config offsets; one-cycle read latency
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "cst_defs.svh"

module cst_clock_ctrl #(
  parameter int unsigned DLY_SHORT_CYC = `CST_DLY_SHORT_CYC,
  parameter int unsigned DLY_LONG_CYC = `CST_DLY_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [`CST_ADDR_W-1:0] regAddr,
  input wire logic [`CST_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`CST_DATA_W-1:0] regRdData,
  // non-volatile configuration
  input wire logic [3:0] clockSourceSelect,
  input wire logic [1:0] startupTimeSelect,
  input wire logic oscOption,
  input wire logic legacyMode,
  // core side
  input wire logic sleepInstr,
  input wire logic irqWake,
  input wire logic wdtTick,
  // clock tree side
  output logic [7:0] trimValue,
  output logic rcEnable,
  output logic [1:0] rcFreqSel,
  output logic extClockSelect,
  output logic mainOscOn,
  output logic ioClockOn,
  output logic cpuHalt,
  output logic sleeping,
  output logic [2:0] activeSleepMode,
  output logic wakeResume,
  output logic configError
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  cst_pkg::cst_regs_t st; // registered state
  cst_pkg::cst_regs_t next_st; // next state
  logic [`CST_SIG_DW-1:0] sigData; // signature row read data
  logic ctrlHit; // write to control register
  logic trimHit; // write to trim register, present only outside legacy mode

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // reset time-out length in watchdog ticks for a start-up select code
  function automatic logic [`CST_CNT_W-1:0] startupDelay(input logic [1:0] startup_time_select);
    logic [`CST_CNT_W-1:0] d;
    d = `CST_STARTUP_CK;
    case (startup_time_select)
      `CST_SUT_NONE: d = `CST_STARTUP_CK;
      `CST_SUT_SHORT: d = `CST_STARTUP_CK + `CST_CNT_W'(DLY_SHORT_CYC);
      default: d = `CST_STARTUP_CK + `CST_CNT_W'(DLY_LONG_CYC); // long and reserved
    endcase
    return d;
  endfunction

  // modes that stop the main oscillator and need a start-up on wake
  function automatic logic deepSleep(input logic [2:0] mode);
    return (mode == `CST_SM_PDOWN) || (mode == `CST_SM_PSAVE);
  endfunction

  // modes this block can enter; standby needs a crystal, which is not offered
  function automatic logic modeUsable(input logic [2:0] mode);
    return (mode == `CST_SM_IDLE) || (mode == `CST_SM_NOISE) || deepSleep(mode);
  endfunction

  // source codes this block supports
  function automatic logic srcValid(input logic [3:0] src);
    return src <= `CST_SRC_RC8;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // signature row, always addressed at the 1 MHz calibration word

  cst_sig_rom u_sig_rom (
    .clk(clk),
    .addr(`CST_SIG_CAL_ADDR),
    .rdData(sigData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  assign ctrlHit = regWr && (regAddr == `CST_REG_CTRL);
  assign trimHit = regWr && (regAddr == `CST_REG_TRIM) && !st.legacy;

  always_comb begin
    next_st = st;
    next_st.resume = 1'b0;
    next_st.rdData = '0;

    // control register: arm bit and mode select; a write clears the mode error
    if (ctrlHit) begin
      next_st.sleepArm = regWrData[`CST_CTRL_ARM];
      next_st.sleepMode = {regWrData[`CST_CTRL_MODE_HI], regWrData[`CST_CTRL_MODE_MID],
        regWrData[`CST_CTRL_MODE_LO]};
      next_st.modeErr = 1'b0;
    end

    // trim register; are software's duty
    if (trimHit) begin
      next_st.trim = regWrData;
    end

    // sequencer
    case (st.state)
      cst_pkg::CST_ST_TIMEOUT: begin
        // time-out advances only on watchdog oscillator ticks
        if (wdtTick) begin
          if (st.cnt <= `CST_CNT_ONE) begin
            next_st.state = cst_pkg::CST_ST_RUN;
            next_st.cnt = '0;
          end else begin
            next_st.cnt = st.cnt - `CST_CNT_ONE;
          end
        end
      end
      cst_pkg::CST_ST_RUN: begin
        // sleep instruction enters sleep only when armed
        if (sleepInstr && st.sleepArm) begin
          if (modeUsable(st.sleepMode)) begin
            next_st.state = cst_pkg::CST_ST_SLEEP;
          end else begin
            next_st.modeErr = 1'b1; // set wins over a same-cycle clear
          end
        end
      end
      cst_pkg::CST_ST_SLEEP: begin
        // enabled interrupt wakes; deep modes add the oscillator start-up
        if (irqWake) begin
          next_st.state = cst_pkg::CST_ST_WAKE;
          next_st.cnt = deepSleep(st.sleepMode) ? (`CST_STARTUP_CK + `CST_WAKE_HALT_CK)
            : `CST_WAKE_HALT_CK;
        end
      end
      cst_pkg::CST_ST_WAKE: begin
        // core stays halted, then resumes into the handler
        if (st.cnt <= `CST_CNT_ONE) begin
          next_st.state = cst_pkg::CST_ST_RUN;
          next_st.cnt = '0;
          next_st.resume = 1'b1;
        end else begin
          next_st.cnt = st.cnt - `CST_CNT_ONE;
        end
      end
      default: begin
        next_st.state = cst_pkg::CST_ST_RUN;
      end
    endcase

    // register reads, data valid in the following cycle only
    if (regRd) begin
      case (regAddr)
        `CST_REG_TRIM: next_st.rdData = st.legacy ? '0 : st.trim;
        `CST_REG_CTRL: begin
          next_st.rdData = `CST_CTRL_RESET;
          next_st.rdData[`CST_CTRL_ARM] = st.sleepArm;
          next_st.rdData[`CST_CTRL_MODE_HI] = st.sleepMode[2];
          next_st.rdData[`CST_CTRL_MODE_MID] = st.sleepMode[1];
          next_st.rdData[`CST_CTRL_MODE_LO] = st.sleepMode[0];
        end
        `CST_REG_STATUS: begin
          next_st.rdData[`CST_STAT_SLEEP] = (st.state == cst_pkg::CST_ST_SLEEP);
          next_st.rdData[`CST_STAT_HALT] = (st.state != cst_pkg::CST_ST_RUN);
          next_st.rdData[`CST_STAT_CFGERR] = st.cfgErr;
          next_st.rdData[`CST_STAT_MODEERR] = st.modeErr;
        end
        `CST_REG_CONFIG: next_st.rdData = {st.legacy, st.oscOpt, st.sutSel, st.srcSel};
        default: next_st.rdData = '0; // unmapped reads zero
      endcase
    end

    // reset: sample configuration, load calibration, restart at the vector
    if (!rst_n) begin
      next_st.state = cst_pkg::CST_ST_TIMEOUT;
      next_st.cnt = startupDelay(startupTimeSelect);
      next_st.trim = sigData[`CST_SIG_DW-1:8];
      next_st.srcSel = clockSourceSelect;
      next_st.sutSel = startupTimeSelect;
      next_st.oscOpt = oscOption;
      next_st.legacy = legacyMode;
      next_st.cfgErr = !srcValid(clockSourceSelect) || (startupTimeSelect == `CST_SUT_RSVD);
      next_st.sleepArm = 1'b0;
      next_st.sleepMode = `CST_SM_IDLE;
      next_st.modeErr = 1'b0;
      next_st.resume = 1'b0;
      next_st.rdData = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; sleep never touches core storage, so contents survive

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign regRdData = st.rdData;
  assign trimValue = st.trim;
  // RC for codes 1..4, unsupported codes fall back to RC 1 MHz
  assign extClockSelect = (st.srcSel == `CST_SRC_EXT);
  assign rcEnable = !extClockSelect;
  assign rcFreqSel = srcValid(st.srcSel) && !extClockSelect ?
    2'(st.srcSel - `CST_SRC_RC1) : 2'(`CST_SRC_FACTORY - `CST_SRC_RC1);
  assign mainOscOn = !((st.state == cst_pkg::CST_ST_SLEEP) && deepSleep(st.sleepMode));
  assign ioClockOn = !((st.state == cst_pkg::CST_ST_SLEEP) && (st.sleepMode != `CST_SM_IDLE));
  assign cpuHalt = (st.state != cst_pkg::CST_ST_RUN);
  assign sleeping = (st.state == cst_pkg::CST_ST_SLEEP);
  assign activeSleepMode = sleeping ? st.sleepMode : `CST_SM_IDLE;
  assign wakeResume = st.resume;
  assign configError = st.cfgErr;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  trim_reset_load_a: assert property (
    $rose(rst_n) |-> (trimValue == sigData[`CST_SIG_DW-1:8]))
    else $error("trim not loaded with calibration at reset");

  config_static_a: assert property (
    $past(rst_n) |-> ($stable(st.srcSel) && $stable(st.sutSel) && $stable(st.legacy)))
    else $error("configuration changed while running");

  timeout_length_a: assert property (
    ($rose(rst_n) && (st.sutSel == `CST_SUT_NONE)) |-> (cpuHalt && (st.cnt == `CST_STARTUP_CK)))
    else $error("wrong reset time-out load");

  timeout_tick_a: assert property (
    (st.state == cst_pkg::CST_ST_TIMEOUT && !wdtTick) |=> $stable(st.cnt))
    else $error("time-out advanced without watchdog tick");

  sleep_unarmed_a: assert property (
    (st.state == cst_pkg::CST_ST_RUN && sleepInstr && !st.sleepArm) |=> !sleeping)
    else $error("sleep entered without arm bit");

  sleep_entry_a: assert property (
    (st.state == cst_pkg::CST_ST_RUN && sleepInstr && st.sleepArm && modeUsable(st.sleepMode))
    |=> (sleeping && activeSleepMode == $past(st.sleepMode)))
    else $error("armed sleep instruction did not enter sleep");

  reserved_mode_a: assert property (
    (st.state == cst_pkg::CST_ST_RUN && sleepInstr && st.sleepArm && !modeUsable(st.sleepMode))
    |=> (!sleeping && st.modeErr))
    else $error("reserved sleep mode not refused");

  deep_wake_a: assert property (
    (sleeping && irqWake && deepSleep(st.sleepMode)) |=>
    (cpuHalt && !wakeResume)[*8] ##1 (cpuHalt && !wakeResume)[*2] ##1 (!cpuHalt && wakeResume))
    else $error("deep wake not halted start-up plus four cycles");

  light_wake_a: assert property (
    (sleeping && irqWake && !deepSleep(st.sleepMode)) |=>
    (cpuHalt && !wakeResume)[*4] ##1 (!cpuHalt && wakeResume))
    else $error("light wake not halted four cycles");

  sleep_keeps_trim_a: assert property (
    (sleeping && !trimHit) |=> $stable(trimValue))
    else $error("trim changed during sleep");

  legacy_trim_a: assert property (
    (regWr && regAddr == `CST_REG_TRIM && st.legacy) |=> $stable(trimValue))
    else $error("trim written in legacy mode");

  source_map_a: assert property (
    (st.srcSel == `CST_SRC_RC8) |-> (rcEnable && !extClockSelect && rcFreqSel == 2'h3))
    else $error("8 MHz source code mis-decoded");

  ////////////////////////////////////////////////////////////////////////////
  // register and source decode checks

  // a trim write lands in the register the cycle after the strobe
  trim_write_a: assert property (
    trimHit
    |=> (trimValue == $past(regWrData)))
    else $error("trim write did not land");

  // in legacy mode the trim register reads back as zero
  legacy_read_a: assert property (
    (regRd && (regAddr == `CST_REG_TRIM) && st.legacy)
    |=> (regRdData == 8'h00))
    else $error("trim readable in legacy mode");

  // code 0000 hands the clock over to the external pin
  ext_source_a: assert property (
    (st.srcSel == `CST_SRC_EXT)
    |-> (extClockSelect && !rcEnable))
    else $error("external clock code mis-decoded");

  // factory code runs the RC oscillator at 1 MHz
  rc1_source_a: assert property (
    (st.srcSel == `CST_SRC_FACTORY)
    |-> (rcEnable && !extClockSelect && (rcFreqSel == 2'h0)))
    else $error("1 MHz source code mis-decoded");

  ////////////////////////////////////////////////////////////////////////////
  // time-out and sleep checks

  // short start-up select loads the added reset delay
  timeout_short_a: assert property (
    ($rose(rst_n) && (st.sutSel == `CST_SUT_SHORT))
    |-> (st.cnt == (`CST_STARTUP_CK + `CST_CNT_W'(DLY_SHORT_CYC))))
    else $error("short reset delay not loaded");

  // long and reserved start-up selects load the long reset delay
  timeout_long_a: assert property (
    ($rose(rst_n) && ((st.sutSel == `CST_SUT_LONG) || (st.sutSel == `CST_SUT_RSVD)))
    |-> (st.cnt == (`CST_STARTUP_CK + `CST_CNT_W'(DLY_LONG_CYC))))
    else $error("long reset delay not loaded");

  // a reset, asleep or not, restarts into the halted time-out
  reset_restart_a: assert property (
    $rose(rst_n)
    |-> (cpuHalt && !sleeping && !wakeResume))
    else $error("reset did not restart into time-out");

  // without an interrupt the core stays asleep
  sleep_hold_a: assert property (
    (sleeping && !irqWake)
    |=> sleeping)
    else $error("left sleep without interrupt");

  // idle keeps the oscillator and the I/O clock running
  idle_clocks_a: assert property (
    (sleeping && (activeSleepMode == `CST_SM_IDLE))
    |-> (mainOscOn && ioClockOn))
    else $error("idle stopped a clock");

  // power-down and power-save stop the main oscillator and the I/O clock
  deep_clocks_a: assert property (
    (sleeping && deepSleep(st.sleepMode))
    |-> (!mainOscOn && !ioClockOn))
    else $error("deep sleep left a clock running");

endmodule

// ### tb/cst_osc_model.sv
// Purpose: watchdog oscillator stand-in that feeds the reset time-out
// Assumes: ticks are aligned to the system clock rising edge
// Notes: slowMode halves the tick rate to mimic a slow oscillator
`timescale 1ns/1ps

module cst_osc_model (
  input wire logic clk,
  input wire logic slowMode,
  output logic wdtTick
);
  ////////////////////////////////////////////////////////////////////////////////
  logic phase; // toggles each cycle, gates ticks in slow mode
  // start ticking at once so the first time-out is not stretched
  initial begin
    phase = 1'b0;
    wdtTick = 1'b1;
  end
  // steady tick rate while slowMode holds; a slowMode change shows at the next edge
  always @(posedge clk) begin
    phase <= ~phase;
    wdtTick <= slowMode ? phase : 1'b1;
  end
endmodule

// ### tb/cst_clock_ctrl_bench.sv
// Purpose: self-checking bench for the clock source, trim and sleep block
// Assumes: long start-up delays shortened to 20 and 40 cycles
// Notes: each scenario is its own task and judges its own results
`timescale 1ns/1ps
`include "cst_defs.svh"

module cst_clock_ctrl_bench;
  localparam int SHORT = 20; // shortened short delay
  localparam int LONG = 40; // shortened long delay
  localparam logic [7:0] CAL1 = 8'h80; // default row calibration, arbitrary
  logic clk, rst_n, regWr, regRd, oscOption, legacyMode, sleepInstr, irqWake;
  logic wdtTick, slowMode, rcEnable, extClockSelect, mainOscOn, ioClockOn;
  logic cpuHalt, sleeping, wakeResume, configError;
  logic [7:0] regAddr, regWrData, regRdData, trimValue;
  logic [3:0] clockSourceSelect; // static source code
  logic [1:0] startupTimeSelect, rcFreqSel;
  logic [2:0] activeSleepMode;
  int fails, cmp_count, cycles;

  ////////////////////////////////////////////////////////////////////////////////
  cst_clock_ctrl #(.DLY_SHORT_CYC(SHORT), .DLY_LONG_CYC(LONG)) u_dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .clockSourceSelect(clockSourceSelect), .startupTimeSelect(startupTimeSelect),
    .oscOption(oscOption), .legacyMode(legacyMode), .sleepInstr(sleepInstr),
    .irqWake(irqWake), .wdtTick(wdtTick), .trimValue(trimValue),
    .rcEnable(rcEnable), .rcFreqSel(rcFreqSel), .extClockSelect(extClockSelect),
    .mainOscOn(mainOscOn), .ioClockOn(ioClockOn), .cpuHalt(cpuHalt),
    .sleeping(sleeping), .activeSleepMode(activeSleepMode),
    .wakeResume(wakeResume), .configError(configError));
  cst_osc_model u_osc (.clk(clk), .slowMode(slowMode), .wdtTick(wdtTick));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // halted length may carry up to two edges of pipeline slack
  task automatic chkHalt(input int n, input int exp);
    chk({7'h0, n >= exp && n <= exp + 2}, 8'h01);
  endtask
  // bus write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask
  // bus read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic pulseSleep;
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    #1;
  endtask
  // reset with a configuration, then count halted cycles
  task automatic doReset(input logic [3:0] s, input logic [1:0] u, input logic l,
                         output int n);
    rst_n <= 1'b0;
    clockSourceSelect <= s;
    startupTimeSelect <= u;
    legacyMode <= l;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    // count from the release cycle, which is already halted
    #1;
    while (cpuHalt === 1'b1 && n < 500) begin
      n++;
      @(posedge clk);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    int n;
    logic [7:0] d;
    doReset(4'h1, 2'h2, 1'b0, n);
    chkHalt(n, 6 + LONG);
    chk(trimValue, CAL1);
    chk({5'h0, rcEnable, rcFreqSel}, 8'h04);
    wr(`CST_REG_CONFIG, 8'hff);
    rd(`CST_REG_CONFIG, d);
    chk(d, 8'h21);
  endtask
  task automatic t_trim;
    logic [7:0] d;
    wr(`CST_REG_TRIM, 8'hff);
    chk(trimValue, 8'hff);
    rd(`CST_REG_TRIM, d);
    chk(d, 8'hff);
    @(posedge clk);
    #1;
    chk(regRdData, 8'h00);
    wr(`CST_REG_TRIM, 8'h00);
    rd(`CST_REG_TRIM, d);
    chk(d, 8'h00);
    rd(8'h7f, d);
    chk(d, 8'h00);
    wr(`CST_REG_STATUS, 8'hff);
    rd(`CST_REG_STATUS, d);
    chk(d, 8'h00);
  endtask
  task automatic t_sources;
    int n;
    for (int s = 0; s < 6; s++) begin
      doReset(4'(s), 2'h0, 1'b0, n);
      chkHalt(n, 6);
      chk({5'h0, configError, rcEnable, extClockSelect}, {5'h0, s > 4, s != 0, s == 0});
      if (s != 0) chk({6'h0, rcFreqSel}, {6'h0, s < 5 ? 2'(s - 1) : 2'h0});
      chk(trimValue, CAL1);
    end
    doReset(4'h0, 2'h1, 1'b0, n);
    chkHalt(n, 6 + SHORT);
    doReset(4'h1, 2'h3, 1'b0, n);
    chkHalt(n, 6 + LONG);
    chk({7'h0, configError}, 8'h01);
    slowMode <= 1'b1;
    doReset(4'h1, 2'h0, 1'b0, n);
    chk({7'h0, n >= 11 && n <= 14}, 8'h01);
    slowMode <= 1'b0;
    doReset(4'h1, 2'h0, 1'b0, n);
  endtask
  task automatic t_noarm;
    logic [7:0] d;
    wr(`CST_REG_CTRL, 8'hff);
    rd(`CST_REG_CTRL, d);
    chk(d, 8'h3c);
    wr(`CST_REG_CTRL, 8'h1c);
    pulseSleep();
    chk({7'h0, sleeping}, 8'h00);
  endtask
  task automatic t_mode(input logic [2:0] m);
    logic [7:0] d;
    int n;
    logic ok;
    ok = (m[2] == 1'b0);
    wr(`CST_REG_TRIM, 8'h5a);
    wr(`CST_REG_CTRL, {2'b00, 1'b1, m[1], m[0], m[2], 2'b00});
    pulseSleep();
    chk({7'h0, sleeping}, {7'h0, ok});
    if (ok) begin
      chk({5'h0, activeSleepMode}, {5'h0, m});
      chk({6'h0, mainOscOn, ioClockOn}, {6'h0, m[1] == 1'b0, m == 3'h0});
      irqWake <= 1'b1;
      n = 0;
      @(posedge clk);
      #1;
      while (cpuHalt === 1'b1 && sleeping === 1'b0 && n < 50) begin
        n++;
        irqWake <= 1'b0;
        @(posedge clk);
        #1;
      end
      irqWake <= 1'b0;
      chk(8'(n), m[1] ? 8'h0a : 8'h04);
      chk({7'h0, wakeResume}, 8'h01);
      chk(trimValue, 8'h5a);
    end else begin
      rd(`CST_REG_STATUS, d);
      chk(d, 8'h08);
    end
  endtask
  task automatic t_resetSleep;
    int n;
    logic [7:0] d;
    wr(`CST_REG_CTRL, 8'h30);
    pulseSleep();
    chk({7'h0, sleeping}, 8'h01);
    doReset(4'h1, 2'h0, 1'b0, n);
    chkHalt(n, 6);
    chk({7'h0, sleeping}, 8'h00);
    rd(`CST_REG_CTRL, d);
    chk(d, `CST_CTRL_RESET);
  endtask
  task automatic t_legacy;
    int n;
    logic [7:0] d;
    doReset(4'h1, 2'h0, 1'b1, n);
    wr(`CST_REG_TRIM, 8'h33);
    rd(`CST_REG_TRIM, d);
    chk(d, 8'h00);
    rd(`CST_REG_CONFIG, d);
    chk(d, 8'h81);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    {regWr, regRd, sleepInstr, irqWake, slowMode, oscOption, legacyMode} = 7'h0;
    {regAddr, regWrData} = 16'h0000;
    clockSourceSelect = 4'h1;
    startupTimeSelect = 2'h2;
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    t_defaults();
    t_trim();
    t_sources();
    t_noarm();
    for (int m = 0; m < 8; m++) begin
      t_mode(3'(m));
    end
    t_resetSleep();
    t_legacy();
    complete_run();
  end
endmodule
